// file: smsw_pkg.sv
`default_nettype none
package smsw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_MHZ         = 200;
   localparam int UV_FILTER_MS    = 40;
   localparam int UV_FILTER_CYC   = UV_FILTER_MS * 1000 * CLK_MHZ;
   localparam int OV_FILTER_US    = 80;
   localparam int OV_FILTER_CYC   = OV_FILTER_US * CLK_MHZ;
   localparam int BIT1_HIGH_US    = 40;
   localparam int BIT1_HIGH_CYC   = BIT1_HIGH_US * CLK_MHZ;
   localparam int BIT0_HIGH_US    = 10;
   localparam int BIT0_HIGH_CYC   = BIT0_HIGH_US * CLK_MHZ;
   localparam int BIT_LOW_US      = 10;
   localparam int BIT_LOW_CYC     = BIT_LOW_US * CLK_MHZ;
   localparam int TM_DELAY_US     = 1000;
   localparam int TM_DELAY_CYC    = TM_DELAY_US * CLK_MHZ;
   localparam int BIAS_PERIOD_US  = 500;
   localparam int BIAS_PERIOD_CYC = BIAS_PERIOD_US * CLK_MHZ;
   localparam int BIAS_ON_US      = 50;
   localparam int BIAS_ON_CYC     = BIAS_ON_US * CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam int         ADR_W      = 4;
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_LAST   = 4'h8;
   localparam int         CTRL_QUERY = 0;
   localparam int         CTRL_TXEN  = 1;
   localparam logic       TXEN_RST   = 1'b1;
   localparam int         STS_WORD   = 0;
   localparam int         STS_CFG    = 7;
   localparam int         STS_OV     = 8;
   localparam int         STS_BUSY   = 9;
   localparam int         STS_PIN    = 10;
   localparam int         STS_UV     = 11;

   ////////////////////////////////////////////////////////////////////////////
   // Status word codes, value is {bit2, bit1, bit0} and {bit4, bit3}
   localparam logic [2:0] SYS_NONE  = 3'h0;
   localparam logic [2:0] SYS_OV    = 3'h4;
   localparam logic [2:0] SYS_UV100 = 3'h2;
   localparam logic [2:0] SYS_UV85  = 3'h6;
   localparam logic [2:0] SYS_UV70  = 3'h1;
   localparam logic [2:0] SYS_UV55  = 3'h5;
   localparam logic [2:0] SYS_THERM = 3'h3;
   localparam logic [2:0] SYS_LS_NR = 3'h7;
   localparam logic [1:0] INT_NONE  = 2'h0;
   localparam logic [1:0] INT_WARN  = 2'h2;
   localparam logic [1:0] INT_SD    = 2'h1;
   localparam logic [1:0] INT_HS_NR = 2'h3;
   localparam int         WORD_W    = 7;
   localparam int         FRAME_W   = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {UV_NONE, UV_100, UV_85, UV_70, UV_55} smsw_uv_t;
   typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} smsw_tx_t;

   typedef struct packed {
      logic above_ov;
      logic ov_hyst_low;
      logic below_uv100;
      logic below_uv85;
      logic below_uv70;
      logic below_uv55;
      logic below_vth;
   } smsw_cmp_t;

   typedef struct packed {
      logic ls_not_ready;
      logic hs_not_ready;
      logic ls_warn;
      logic ls_sd;
      logic ls_oc;
      logic hs_oc;
   } smsw_int_t;

endpackage
`default_nettype wire

// file: smsw_top.sv
// Overview of operation
// [R1] Monitor pin mode is caught once after reset and then held fixed.
// [R2] Bus mode compares against four undervoltage levels and one overvoltage.
// [R3] Any undervoltage or overvoltage condition changes the word and sends it.
// [R4] Undervoltage is reported only after persisting for the filter time.
// [R5] Undervoltage clearing is reported after absence for the filter time.
// [R6] A cleared deep level reports the still present shallower level.
// [R7] Overvoltage held for its filter time ends on-time and is reported.
// [R8] After trip all turn-on requests ignored until hysteresis held filter time.
// [R9] Clearing of bus overvoltage sends a fresh status update.
// [R10] Thermistor mode pulses bias, flags low voltage after thermal delay.
// [R11] Status pin only pulled low or released, open drain.
// [R12] Each update is seven status bits then one parity bit.
// [R13] Parity makes the eight transmitted bits hold an odd count of ones.
// [R14] Bits 0 to 2 carry the system condition code.
// [R15] Bits 3 and 4 carry the internal condition code.
// [R16] Bit 5 flags low-side over-current, bit 6 high-side over-current.
// [R17] Cleared conditions in bits 0 to 4 are reported.
// [R18] All-zero word sent after power-up and on query with no fault.
// [R19] Not-ready codes gather link, supply and limit pin faults.
// [R20] One is 40 us released, zero 10 us, each then 10 us low.
// [R21] Each change sent once; thermal shutdown never reported as cleared.
// [R22] Word sent bit 0 first through bit 6, parity last.
// [R23] Comparator outputs pass a two-flop synchroniser first.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module smsw_top #(
   parameter int UV_CYC       = smsw_pkg::UV_FILTER_CYC,
   parameter int OV_CYC       = smsw_pkg::OV_FILTER_CYC,
   parameter int BIT1_CYC     = smsw_pkg::BIT1_HIGH_CYC,
   parameter int TM_CYC       = smsw_pkg::TM_DELAY_CYC,
   parameter int BIAS_PER_CYC = smsw_pkg::BIAS_PERIOD_CYC,
   parameter int BIAS_ON_CYC  = smsw_pkg::BIAS_ON_CYC
) (
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [smsw_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   // Monitor pin front end
   input  wire logic                        monitor_cfg_thermistor_i,
   input  wire smsw_pkg::smsw_cmp_t         cmp_i,
   output logic                             thermistor_bias_current_en_o,
   // Internal fault sources
   input  wire smsw_pkg::smsw_int_t         int_fault_i,
   // Drive requests and gate enables
   input  wire logic                        low_side_drive_request_i,
   input  wire logic                        high_side_drive_request_n_i,
   output logic                             low_side_gate_o,
   output logic                             high_side_gate_o,
   // Open-drain status pin
   input  wire logic                        status_pin_i,
   output logic                             status_pin_o,
   output logic                             status_pin_oe_o
);

   localparam int CW = 24;
   localparam logic [CW-1:0] UV_LIM   = CW'(UV_CYC - 1);
   localparam logic [CW-1:0] OV_LIM   = CW'(OV_CYC - 1);
   localparam logic [CW-1:0] TM_LIM   = CW'(TM_CYC - 1);
   localparam logic [CW-1:0] B1_LIM   = CW'(BIT1_CYC - 1);
   localparam logic [CW-1:0] B0_LIM   = CW'(smsw_pkg::BIT0_HIGH_CYC - 1);
   localparam logic [CW-1:0] LOW_LIM  = CW'(smsw_pkg::BIT_LOW_CYC - 1);
   localparam logic [CW-1:0] PER_LIM  = CW'(BIAS_PER_CYC - 1);
   localparam logic [CW-1:0] ON_LIM   = CW'(BIAS_ON_CYC - 1);

   if (UV_CYC < 2 || OV_CYC < 2 || TM_CYC < 2 || BIT1_CYC < 2 ||
       BIAS_ON_CYC < 2 || BIAS_PER_CYC <= BIAS_ON_CYC ||
       UV_CYC >= 2**CW || OV_CYC >= 2**CW || TM_CYC >= 2**CW ||
       BIT1_CYC >= 2**CW || BIAS_PER_CYC >= 2**CW) begin : g_bad_param
      $error("smsw_top: timing parameter out of range");
   end

   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] c,
                                              input logic [CW-1:0] lim);
      sat_inc = (c >= lim) ? lim : c + 1'b1;
   endfunction

   function automatic smsw_pkg::smsw_uv_t uv_level(
         input smsw_pkg::smsw_cmp_t c);
      if (c.below_uv55)
         uv_level = smsw_pkg::UV_55;
      else if (c.below_uv70)
         uv_level = smsw_pkg::UV_70;
      else if (c.below_uv85)
         uv_level = smsw_pkg::UV_85;
      else if (c.below_uv100)
         uv_level = smsw_pkg::UV_100;
      else
         uv_level = smsw_pkg::UV_NONE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Mode strap and synchroniser

   logic                 cfg_valid_q;
   logic                 cfg_therm_q;
   smsw_pkg::smsw_cmp_t  sync1_q;
   smsw_pkg::smsw_cmp_t  cmp_s;
   wire                  bus_mode = cfg_valid_q & ~cfg_therm_q;
   wire                  tm_mode  = cfg_valid_q & cfg_therm_q;

   // [R1] strap caught once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_valid_q <= 1'b0;
         cfg_therm_q <= 1'b0;
      end else if (!cfg_valid_q) begin
         cfg_valid_q <= 1'b1;
         cfg_therm_q <= monitor_cfg_thermistor_i;
      end
   end

   // [R23] two-flop synchroniser
   always_ff @(posedge clk_i) begin
      sync1_q <= cmp_i;
      cmp_s   <= sync1_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Undervoltage filter

   smsw_pkg::smsw_uv_t  uv_cand_q;
   smsw_pkg::smsw_uv_t  uv_rep_q;
   logic [CW-1:0]       uv_cnt_q;
   smsw_pkg::smsw_uv_t  uv_raw;

   // [R2] deepest undervoltage level
   assign uv_raw = bus_mode ? uv_level(cmp_s) : smsw_pkg::UV_NONE;

   // [R4] [R5] [R6] level must hold the filter time to change report
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         uv_cand_q <= smsw_pkg::UV_NONE;
         uv_rep_q  <= smsw_pkg::UV_NONE;
         uv_cnt_q  <= '0;
      end else if (uv_raw != uv_cand_q) begin
         uv_cand_q <= uv_raw;
         uv_cnt_q  <= '0;
      end else if (uv_cand_q != uv_rep_q) begin
         if (uv_cnt_q == UV_LIM) begin
            uv_rep_q <= uv_cand_q;
            uv_cnt_q <= '0;
         end else begin
            uv_cnt_q <= sat_inc(uv_cnt_q, UV_LIM);
         end
      end else begin
         uv_cnt_q <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overvoltage trip and drive gating

   logic           ov_block_q;
   logic [CW-1:0]  ov_cnt_q;
   logic           ls_gate_q;
   logic           hs_gate_q;
   wire            ov_cond  = ov_block_q ? cmp_s.ov_hyst_low : cmp_s.above_ov;
   wire            ov_trip  = bus_mode & ~ov_block_q & cmp_s.above_ov &
                              (ov_cnt_q == OV_LIM);
   wire            ov_block_now = ov_block_q | ov_trip;

   // [R7] [R8] trip after filter time, release after hysteresis time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ov_block_q <= 1'b0;
         ov_cnt_q   <= '0;
      end else if (!bus_mode || !ov_cond) begin
         ov_cnt_q   <= '0;
      end else if (ov_cnt_q == OV_LIM) begin
         ov_block_q <= ~ov_block_q;
         ov_cnt_q   <= '0;
      end else begin
         ov_cnt_q   <= sat_inc(ov_cnt_q, OV_LIM);
      end
   end

   // [R8] turn-on requests ignored while blocked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ls_gate_q <= 1'b0;
         hs_gate_q <= 1'b0;
      end else begin
         ls_gate_q <= low_side_drive_request_i & ~ov_block_now;
         hs_gate_q <= ~high_side_drive_request_n_i & ~ov_block_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Thermistor bias and thermal delay

   logic [CW-1:0]  bias_cnt_q;
   logic           bias_q;
   logic           tm_low_q;
   logic           tm_flt_q;
   logic [CW-1:0]  tm_cnt_q;

   // [R10] periodic bias, sample at end of window
   always_ff @(posedge clk_i) begin
      if (rst_i || !tm_mode) begin
         bias_cnt_q <= '0;
         bias_q     <= 1'b0;
         tm_low_q   <= 1'b0;
      end else begin
         bias_cnt_q <= (bias_cnt_q == PER_LIM) ? '0 : bias_cnt_q + 1'b1;
         bias_q     <= (bias_cnt_q < ON_LIM) || (bias_cnt_q == PER_LIM);
         if (bias_cnt_q == ON_LIM)
            tm_low_q <= cmp_s.below_vth;
      end
   end

   // [R10] fault and clear after the thermal delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tm_flt_q <= 1'b0;
         tm_cnt_q <= '0;
      end else if (tm_low_q == tm_flt_q) begin
         tm_cnt_q <= '0;
      end else if (tm_cnt_q == TM_LIM) begin
         tm_flt_q <= tm_low_q;
         tm_cnt_q <= '0;
      end else begin
         tm_cnt_q <= sat_inc(tm_cnt_q, TM_LIM);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status word

   logic                           sd_q;
   logic [2:0]                     sys_code;
   logic [1:0]                     int_code;
   logic [smsw_pkg::WORD_W-1:0]    word_now;

   // [R21] shutdown latched, never reported cleared
   always_ff @(posedge clk_i) begin
      if (rst_i)
         sd_q <= 1'b0;
      else
         sd_q <= sd_q | int_fault_i.ls_sd;
   end

   // [R14] [R19] [R3] [R9] system field
   assign sys_code =
      int_fault_i.ls_not_ready        ? smsw_pkg::SYS_LS_NR :
      ov_block_q                      ? smsw_pkg::SYS_OV    :
      (tm_mode && tm_flt_q)           ? smsw_pkg::SYS_THERM :
      (uv_rep_q == smsw_pkg::UV_55)   ? smsw_pkg::SYS_UV55  :
      (uv_rep_q == smsw_pkg::UV_70)   ? smsw_pkg::SYS_UV70  :
      (uv_rep_q == smsw_pkg::UV_85)   ? smsw_pkg::SYS_UV85  :
      (uv_rep_q == smsw_pkg::UV_100)  ? smsw_pkg::SYS_UV100 :
                                        smsw_pkg::SYS_NONE;

   // [R15] [R19] internal field
   assign int_code =
      int_fault_i.hs_not_ready ? smsw_pkg::INT_HS_NR :
      sd_q                     ? smsw_pkg::INT_SD    :
      int_fault_i.ls_warn      ? smsw_pkg::INT_WARN  :
                                 smsw_pkg::INT_NONE;

   // [R16] [R17] independent groups in one word
   assign word_now = {int_fault_i.hs_oc, int_fault_i.ls_oc, int_code,
                      sys_code};

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter

   smsw_pkg::smsw_tx_t              st_q;
   smsw_pkg::smsw_tx_t              st_d;
   logic [CW-1:0]                   bcnt_q;
   logic [CW-1:0]                   bcnt_d;
   logic [2:0]                      idx_q;
   logic [2:0]                      idx_d;
   logic [smsw_pkg::FRAME_W-1:0]    frame_q;
   logic [smsw_pkg::FRAME_W-1:0]    last_q;
   logic                            boot_q;
   logic                            query_q;
   logic                            tx_en_q;
   logic                            oe_q;
   wire  [CW-1:0]                   hi_lim = frame_q[idx_q] ? B1_LIM : B0_LIM;
   wire                             changed = word_now != last_q[6:0];
   wire                             tx_start = (st_q == smsw_pkg::ST_IDLE) &
                                               tx_en_q & cfg_valid_q &
                                               (changed | query_q | boot_q);

   // [R20] [R22] bit timing, bit 0 first, parity last
   always_comb begin
      st_d   = st_q;
      bcnt_d = bcnt_q;
      idx_d  = idx_q;
      unique case (st_q)
         smsw_pkg::ST_IDLE: begin
            if (tx_start) begin
               st_d   = smsw_pkg::ST_HIGH;
               bcnt_d = '0;
               idx_d  = 3'h0;
            end
         end
         smsw_pkg::ST_HIGH: begin
            bcnt_d = bcnt_q + 1'b1;
            if (bcnt_q == hi_lim) begin
               st_d   = smsw_pkg::ST_LOW;
               bcnt_d = '0;
            end
         end
         smsw_pkg::ST_LOW: begin
            bcnt_d = bcnt_q + 1'b1;
            if (bcnt_q == LOW_LIM) begin
               bcnt_d = '0;
               idx_d  = idx_q + 3'h1;
               st_d   = (idx_q == 3'h7) ? smsw_pkg::ST_IDLE
                                        : smsw_pkg::ST_HIGH;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q   <= smsw_pkg::ST_IDLE;
         bcnt_q <= '0;
         idx_q  <= 3'h0;
         oe_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         bcnt_q <= bcnt_d;
         idx_q  <= idx_d;
         oe_q   <= st_d == smsw_pkg::ST_LOW;
      end
   end

   // [R12] [R13] [R21] frame load with odd parity, once per change
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_q <= '0;
         last_q  <= '0;
      end else if (tx_start) begin
         frame_q <= {~^word_now, word_now};
         last_q  <= {~^word_now, word_now};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   logic [31:0]  sts;
   logic [31:0]  rd_mux;
   wire          req    = wb_cyc_i & wb_stb_i;
   wire          wr_ctl = req & wb_ack_o & wb_we_i & wb_sel_i[0] &
                          (wb_adr_i == smsw_pkg::REG_CTRL);
   wire          q_set  = wr_ctl & wb_dat_i[smsw_pkg::CTRL_QUERY];

   always_comb begin
      sts = '0;
      sts[smsw_pkg::STS_WORD +: smsw_pkg::WORD_W] = word_now;
      sts[smsw_pkg::STS_CFG]    = cfg_therm_q;
      sts[smsw_pkg::STS_OV]     = ov_block_q;
      sts[smsw_pkg::STS_BUSY]   = st_q != smsw_pkg::ST_IDLE;
      sts[smsw_pkg::STS_PIN]    = status_pin_i;
      sts[smsw_pkg::STS_UV +: 3] = uv_rep_q;
   end

   assign rd_mux =
      (wb_adr_i == smsw_pkg::REG_CTRL)   ? {30'h0, tx_en_q, query_q} :
      (wb_adr_i == smsw_pkg::REG_STATUS) ? sts :
      (wb_adr_i == smsw_pkg::REG_LAST)   ? {24'h0, last_q} :
                                           32'h0;

   // [R18] ready word after power-up and on query; set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         tx_en_q  <= smsw_pkg::TXEN_RST;
         query_q  <= 1'b0;
         boot_q   <= 1'b1;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= (req & ~wb_ack_o) ? rd_mux : 32'h0;
         if (wr_ctl)
            tx_en_q <= wb_dat_i[smsw_pkg::CTRL_TXEN];
         query_q  <= (query_q & ~tx_start) | q_set;
         boot_q   <= boot_q & ~tx_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // [R11] never driven high
   assign status_pin_o                 = 1'b0;
   assign status_pin_oe_o              = oe_q;
   assign low_side_gate_o              = ls_gate_q;
   assign high_side_gate_o             = hs_gate_q;
   assign thermistor_bias_current_en_o = bias_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_cfg_fixed: assert property (cfg_valid_q |=> $stable(cfg_therm_q)) // R1
      else $error("mode strap changed after capture");
   chk_uv_report: assert property ($changed(uv_rep_q) |->  // R4
      $past(uv_cnt_q) == UV_LIM && $past(uv_cand_q) == uv_rep_q)
      else $error("undervoltage report without full filter time");
   chk_ov_trip: assert property (ov_trip |=> ov_block_q) // R7
      else $error("overvoltage trip missed");
   chk_ov_gate: assert property (ov_block_q |=> !ls_gate_q && !hs_gate_q) // R8
      else $error("gate enabled during overvoltage block");
   chk_sys_code: assert property (ov_block_q && !int_fault_i.ls_not_ready  // R14
      |-> word_now[2:0] == smsw_pkg::SYS_OV)
      else $error("overvoltage code wrong");
   chk_sd_sticky: assert property (sd_q |=> sd_q && word_now[4:3] != 2'h0 ||  // R21
      int_fault_i.hs_not_ready)
      else $error("thermal shutdown reported cleared");
   chk_frame_parity: assert property (st_q != smsw_pkg::ST_IDLE |->  // R13
      ^frame_q == 1'b1)
      else $error("frame parity not odd");
   chk_frame_load: assert property (tx_start |=>  // R12
      frame_q[6:0] == $past(word_now) && last_q == frame_q)
      else $error("frame load wrong");
   chk_pin_od: assert property (status_pin_o == 1'b0 &&  // R11
      (status_pin_oe_o == (st_q == smsw_pkg::ST_LOW)))
      else $error("status pin drive wrong");
   chk_bit_high: assert property ($rose(st_q == smsw_pkg::ST_LOW) |->  // R20
      $past(bcnt_q) == $past(hi_lim))
      else $error("bit high time wrong");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   cov_tx_start: cover property (tx_start);
   cov_ov_trip: cover property ($rose(ov_block_q));
   cov_uv_level: cover property ($changed(uv_rep_q));
   cov_tm_fault: cover property ($rose(tm_flt_q));

endmodule
`default_nettype wire

// file: smsw_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
module smsw_mcu_model #(
   parameter int THR = 1000
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Shared status wire
   input  wire logic        wire_i,
   // Decoded frame
   output logic      [7:0]  frame_o,
   output logic             frame_vld_o,
   output logic      [15:0] low_len_o
);
   logic [15:0] hi_q;
   logic [15:0] lo_q;
   logic [2:0]  n_q;
   logic [7:0]  sh_q;
   logic        bit_w;

   // Short released interval decodes as one
   assign bit_w = (hi_q < 16'(THR));

   always_ff @(posedge clk_i) begin
      frame_vld_o <= 1'b0;
      if (rst_i) begin
         hi_q      <= 16'h0;
         lo_q      <= 16'h0;
         n_q       <= 3'h0;
         sh_q      <= 8'h0;
         frame_o   <= 8'h0;
         low_len_o <= 16'h0;
      end else if (wire_i) begin
         hi_q <= hi_q + 16'h1;
         if (lo_q != 16'h0) begin
            low_len_o <= lo_q;
            lo_q      <= 16'h0;
         end
      end else begin
         lo_q <= lo_q + 16'h1;
         if (hi_q != 16'h0) begin
            sh_q <= {bit_w, sh_q[7:1]};
            n_q  <= n_q + 3'h1;
            hi_q <= 16'h0;
            if (n_q == 3'h7) begin
               frame_o     <= {bit_w, sh_q[7:1]};
               frame_vld_o <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: system_monitor_status_word_test.sv
`timescale 1ns/100ps
`default_nettype none
module system_monitor_status_word_test;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                cyc = 1'b0;
   logic                stb = 1'b0;
   logic                we = 1'b0;
   logic [3:0]          adr = 4'h0;
   logic [31:0]         dat = 32'h0;
   logic [31:0]         rdat;
   logic                ack;
   smsw_pkg::smsw_cmp_t cmp = '0;
   smsw_pkg::smsw_int_t flt = '0;
   logic                lreq = 1'b0;
   logic                hreq_n = 1'b1;
   logic                lgate;
   logic                hgate;
   logic                pin_o;
   logic                oe;
   wire logic           bus_w;
   logic [7:0]          frm;
   logic                frm_vld;
   logic [15:0]         low_len;
   logic                r;
   logic [3:0]          sel = 4'h0;
   logic [3:0]          sel_nx = 4'hf;
   logic                therm = 1'b0;
   logic                bias;
   int                  n = 0;
   int                  mismatches = 0;
   int                  checks_done = 0;
   int                  frames_seen = 0;
   logic [31:0]         rd_exp[$];
   logic [31:0]         rd_msk[$];
   logic [7:0]          frm_exp[$];
   localparam int       TB_UV  = 40;
   localparam int       TB_OV  = 20;
   localparam int       TB_B1  = 40;
   localparam int       TB_TM  = 20;
   localparam int       TB_PER = 50;
   localparam int       TB_ON  = 10;
   localparam int       TB_THR = 1000;

   always #2.5 clk = ~clk;
   // Pull-up on the shared wire
   assign bus_w = oe ? pin_o : 1'b1;

   smsw_top #(.UV_CYC(TB_UV), .OV_CYC(TB_OV), .BIT1_CYC(TB_B1),
      .TM_CYC(TB_TM), .BIAS_PER_CYC(TB_PER), .BIAS_ON_CYC(TB_ON)) uut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .monitor_cfg_thermistor_i(therm),
      .cmp_i(cmp), .thermistor_bias_current_en_o(bias), .int_fault_i(flt),
      .low_side_drive_request_i(lreq),
      .high_side_drive_request_n_i(hreq_n), .low_side_gate_o(lgate),
      .high_side_gate_o(hgate), .status_pin_i(bus_w),
      .status_pin_o(pin_o), .status_pin_oe_o(oe));

   smsw_mcu_model #(.THR(TB_THR)) mcu (
      .clk_i(clk), .rst_i(rst), .wire_i(bus_w), .frame_o(frm),
      .frame_vld_o(frm_vld), .low_len_o(low_len));

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m);
      if (!w) begin
         rd_exp.push_back(e);
         rd_msk.push_back(m);
      end
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= sel_nx;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
      @(posedge clk);
   endtask

   task automatic push_frame(input logic [6:0] w);
      frm_exp.push_back({~(^w), w});
   endtask

   task automatic gates(input logic blk);
      for (int i = 0; i < 6; i++) begin
         r = 1'($urandom);
         lreq <= r;
         hreq_n <= r;
         repeat (2) @(posedge clk);
         check("ls_gate", 32'(lgate), 32'(r & !blk));
         check("hs_gate", 32'(hgate), 32'(!r & !blk));
      end
   endtask

   always @(posedge clk) begin
      if (frm_vld) begin
         check("frame", 32'(frm), 32'(frm_exp.pop_front()));
         check("low_len", 32'(low_len), 32'(smsw_pkg::BIT_LOW_CYC));
         frames_seen++;
      end
      if (ack && !we)
         check("rd", rdat & rd_msk.pop_front(), rd_exp.pop_front());
   end

   initial begin
      repeat (95000) @(posedge clk);
      mismatches++;
      summarize();
   end

   initial begin
      void'($urandom(32'he4935f38));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      push_frame(7'h00);
      wb(1'b0, 4'h0, 32'h0, 32'h2, 32'hffffffff);
      wb(1'b1, 4'hc, $urandom, 32'h0, 32'h0);
      wb(1'b0, 4'hc, 32'h0, 32'h0, 32'hffffffff);
      wb(1'b0, 4'h4, 32'h0, 32'h0, 32'h1ff);
      gates(1'b0);
      lreq <= 1'b1;
      hreq_n <= 1'b1;
      cmp <= 7'h58;
      flt <= 6'h13;
      push_frame(7'h7c);
      repeat (50) @(posedge clk);
      check("trip_gate", 32'(lgate), 32'h0);
      wb(1'b0, 4'h4, 32'h0, 32'h117c, 32'h39ff);
      gates(1'b1);
      wait (frames_seen == 1);
      repeat (2100) @(posedge clk);
      cmp <= 7'h30;
      flt <= '0;
      push_frame(7'h02);
      repeat (40) @(posedge clk);
      gates(1'b0);
      wb(1'b0, 4'h4, 32'h0, 32'h802, 32'h39ff);
      wait (frames_seen == 3);
      repeat (10) @(posedge clk);
      // Second power-up in thermistor mode with a shutdown pulse
      rst <= 1'b1;
      therm <= 1'b1;
      cmp <= 7'h01;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      flt <= 6'h04;
      sel_nx = 4'he;
      wb(1'b1, 4'h0, 32'h0, 32'h0, 32'h0);
      sel_nx = 4'hf;
      flt <= '0;
      wb(1'b1, 4'h0, 32'h3, 32'h0, 32'h0);
      wb(1'b0, 4'h0, 32'h0, 32'h3, 32'hffffffff);
      repeat (2 * TB_PER) begin
         @(posedge clk);
         n += bias;
      end
      check("bias", n, 2 * TB_ON);
      wb(1'b0, 4'h4, 32'h0, 32'h8b, 32'h1ff);
      summarize();
   end
endmodule
`default_nettype wire
